/* core/host_irq_engine.sv */
`timescale 1ns/10ps
`default_nettype none
`include "usb_irq_cfg.svh"

module host_irq_engine #(
    parameter logic [15:0] IMPL_MASK = 16'hFFFF
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Enable register write.
    input wire logic en_we,
    input wire logic [15:0] en_wdata,
    // Flag set and write-one-to-clear masks.
    input wire logic [15:0] set_mask,
    input wire logic [15:0] clr_mask,
    // State.
    output logic [15:0] enable_reg,
    output logic [15:0] flag_reg,
    output logic irq_reg
);

    logic [15:0] enable_next;
    logic [15:0] flag_next;
    logic irq_next;

    // Unimplemented bits never hold a one; a set in the clear cycle wins.
    always_comb begin
        enable_next = enable_reg;
        if (en_we) begin
            enable_next = en_wdata & IMPL_MASK; // [R2] [R4]
        end
        flag_next = ((flag_reg & ~clr_mask) | set_mask) & IMPL_MASK; // [R13] [R4]
        irq_next = |(flag_next & enable_next); // [R17] [R2]
    end

    // Register the engine state.
    always_ff @(posedge clk) begin
        if (rst) begin
            enable_reg <= `ENABLE_RESET; // [R16]
            flag_reg <= `FLAG_RESET;
            irq_reg <= 1'b0;
        end else begin
            enable_reg <= enable_next;
            flag_reg <= flag_next;
            irq_reg <= irq_next;
        end
    end

endmodule : host_irq_engine
`default_nettype wire

/* core/usb_host_interrupt_status.sv */
// Function
// R1 - Seven-bit target device address, loaded by firmware before each transaction.
// R2 - Enable bit one lets its source interrupt; zero blocks it.
// R3 - Bit 15 covers VBUS crossing the 4.4V threshold, both directions, OTG port.
// R4 - VBUS and ID bits exist only in engine one; reserved in engine two.
// R5 - Bit 14 covers every rising and falling edge of the OTG ID pin.
// R6 - Flag bit 9 sets on SOF/EOP timer expiry; enable 9 gates it.
// R7 - Bits 7 and 6 cover remote wakeup of second and first port.
// R8 - Bits 5 and 4 cover connect change on attach or detach.
// R9 - Second port connect flag sets on either SE0 edge; SE0 status distinguishes.
// R10 - Status bits 3 and 2 show live SE0 of second and first port.
// R11 - Bit 0 flags done on host ACK, device ACK, NAK, STALL or timeout.
// R12 - One done flag serves both ports of an engine.
// R13 - Writing one clears a flag; writing zero leaves it.
// R14 - Status registers reachable from on-chip processor and parallel host port.
// R15 - Software writes zero to every reserved bit.
// R16 - All enable bits read zero after reset.
// R17 - Interrupt asserts while any flag and its enable are both set.
`timescale 1ns/10ps
`default_nettype none
`include "usb_irq_cfg.svh"

module usb_host_interrupt_status
    import usb_irq_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register access from the on-chip processor.
    input wire reg_req_t cpu_req,
    output reg_rsp_t cpu_rsp_reg,
    // Register access from the parallel_host_port.
    input wire reg_req_t parallel_host_port_req,
    output reg_rsp_t parallel_host_port_rsp_reg,
    // Events of both host engines, index 0 is engine one.
    input wire host_event_t [1:0] host_event,
    // OTG levels of the otg_capable_port.
    input wire logic vbus_above_thresh,
    input wire logic otg_id,
    // Outputs to the engines and processor.
    output logic [1:0][6:0] dev_addr_reg,
    output logic [1:0] host_irq_reg
);

    // ****************************************
    // Address decode.
    // ****************************************
    localparam logic [1:0][15:0] EN_OFF = {`HOST_TWO_EN_OFF, `HOST_ONE_EN_OFF};
    localparam logic [1:0][15:0] STAT_OFF = {`HOST_TWO_STAT_OFF, `HOST_ONE_STAT_OFF};
    localparam logic [1:0][15:0] ADDR_OFF = {`HOST_TWO_ADDR_OFF, `HOST_ONE_ADDR_OFF};

    logic [1:0] cpu_en_wr;
    logic [1:0] hpp_en_wr;
    logic [1:0] cpu_st_wr;
    logic [1:0] hpp_st_wr;
    logic [1:0] cpu_ad_wr;
    logic [1:0] hpp_ad_wr;

    // Write strobes per engine and per port.
    always_comb begin
        for (int e = 0; e < 2; e++) begin
            cpu_en_wr[e] = cpu_req.sel && cpu_req.wr && (cpu_req.addr == EN_OFF[e]);
            hpp_en_wr[e] = parallel_host_port_req.sel && parallel_host_port_req.wr
                && (parallel_host_port_req.addr == EN_OFF[e]);
            cpu_st_wr[e] = cpu_req.sel && cpu_req.wr && (cpu_req.addr == STAT_OFF[e]);
            hpp_st_wr[e] = parallel_host_port_req.sel && parallel_host_port_req.wr
                && (parallel_host_port_req.addr == STAT_OFF[e]); // [R14]
            cpu_ad_wr[e] = cpu_req.sel && cpu_req.wr && (cpu_req.addr == ADDR_OFF[e]);
            hpp_ad_wr[e] = parallel_host_port_req.sel && parallel_host_port_req.wr
                && (parallel_host_port_req.addr == ADDR_OFF[e]);
        end
    end

    // ****************************************
    // Edge history of levels.
    // ****************************************
    logic [1:0][1:0] se0_prev_reg;
    logic [1:0][1:0] se0_prev_next;
    logic vbus_prev_reg;
    logic vbus_prev_next;
    logic id_prev_reg;
    logic id_prev_next;
    logic armed_reg;
    logic armed_next;

    // Previous levels; no edge is seen until the first sample after reset.
    always_comb begin
        for (int e = 0; e < 2; e++) begin
            se0_prev_next[e] = host_event[e].se0;
        end
        vbus_prev_next = vbus_above_thresh;
        id_prev_next = otg_id;
        armed_next = 1'b1;
    end

    // Register the level history and the arming flag.
    always_ff @(posedge clk) begin
        if (rst) begin
            se0_prev_reg <= '0;
            vbus_prev_reg <= 1'b0;
            id_prev_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else begin
            se0_prev_reg <= se0_prev_next;
            vbus_prev_reg <= vbus_prev_next;
            id_prev_reg <= id_prev_next;
            armed_reg <= armed_next;
        end
    end

    // ****************************************
    // Event set and clear masks.
    // ****************************************
    logic [1:0][15:0] set_mask;
    logic [1:0][15:0] clr_mask;
    logic [1:0][15:0] en_wdata;
    logic [1:0] en_we;
    logic [1:0] conn_edge;

    // Events become flag sets; clears from both ports combine.
    always_comb begin
        for (int e = 0; e < 2; e++) begin
            set_mask[e] = 16'h0000;
            conn_edge = armed_reg ? (host_event[e].se0 ^ se0_prev_reg[e]) : 2'b00;
            set_mask[e][`BIT_SOF] = host_event[e].sof_expire; // [R6]
            set_mask[e][`BIT_WAKE_B] = host_event[e].wake[1]; // [R7]
            set_mask[e][`BIT_WAKE_A] = host_event[e].wake[0]; // [R7]
            set_mask[e][`BIT_CONN_B] = conn_edge[1]; // [R8] [R9]
            set_mask[e][`BIT_CONN_A] = conn_edge[0]; // [R8]
            set_mask[e][`BIT_DONE] = |(host_event[e].host_ack | host_event[e].dev_ack
                | host_event[e].dev_nak | host_event[e].dev_stall
                | host_event[e].timeout); // [R11] [R12]
            clr_mask[e] = (cpu_st_wr[e] ? cpu_req.wdata : 16'h0000)
                | (hpp_st_wr[e] ? parallel_host_port_req.wdata : 16'h0000); // [R13] [R14]
            en_we[e] = cpu_en_wr[e] | hpp_en_wr[e];
            en_wdata[e] = cpu_en_wr[e] ? cpu_req.wdata : parallel_host_port_req.wdata;
        end
        set_mask[0][`BIT_VBUS] = armed_reg && (vbus_above_thresh != vbus_prev_reg); // [R3]
        set_mask[0][`BIT_ID] = armed_reg && (otg_id != id_prev_reg); // [R5]
    end

    // ****************************************
    // Engines.
    // ****************************************
    logic [1:0][15:0] enable_q;
    logic [1:0][15:0] flag_q;

    host_irq_engine #(
        .IMPL_MASK(`MASK_ENGINE_ONE)
    ) u_engine_one (
        .clk(clk),
        .rst(rst),
        .en_we(en_we[0]),
        .en_wdata(en_wdata[0]),
        .set_mask(set_mask[0]),
        .clr_mask(clr_mask[0]),
        .enable_reg(enable_q[0]),
        .flag_reg(flag_q[0]),
        .irq_reg(host_irq_reg[0])
    );

    host_irq_engine #(
        .IMPL_MASK(`MASK_ENGINE_TWO)
    ) u_engine_two (
        .clk(clk),
        .rst(rst),
        .en_we(en_we[1]),
        .en_wdata(en_wdata[1]),
        .set_mask(set_mask[1]),
        .clr_mask(clr_mask[1]),
        .enable_reg(enable_q[1]),
        .flag_reg(flag_q[1]),
        .irq_reg(host_irq_reg[1])
    ); // [R4]

    // ****************************************
    // Device address registers.
    // ****************************************
    logic [1:0][6:0] dev_addr_next;

    // On-chip processor wins when both ports write the same cycle.
    always_comb begin
        for (int e = 0; e < 2; e++) begin
            dev_addr_next[e] = dev_addr_reg[e];
            if (cpu_ad_wr[e]) begin
                dev_addr_next[e] = cpu_req.wdata[6:0]; // [R1]
            end else if (hpp_ad_wr[e]) begin
                dev_addr_next[e] = parallel_host_port_req.wdata[6:0]; // [R1]
            end
        end
    end

    // Register the target device addresses.
    always_ff @(posedge clk) begin
        if (rst) begin
            dev_addr_reg <= {2{`DEV_ADDR_RESET}};
        end else begin
            dev_addr_reg <= dev_addr_next;
        end
    end

    // ****************************************
    // Read answers.
    // ****************************************
    logic [1:0][15:0] status_view;
    reg_rsp_t cpu_rsp_next;
    reg_rsp_t hpp_rsp_next;

    // Status view merges sticky flags with live SE0 levels.
    always_comb begin
        for (int e = 0; e < 2; e++) begin
            status_view[e] = flag_q[e] & ~`MASK_SE0;
            status_view[e][`BIT_SE0_B] = host_event[e].se0[1]; // [R10]
            status_view[e][`BIT_SE0_A] = host_event[e].se0[0]; // [R10]
        end
        cpu_rsp_next = '0;
        hpp_rsp_next = '0;
        cpu_rsp_next.valid = cpu_req.sel && !cpu_req.wr;
        hpp_rsp_next.valid = parallel_host_port_req.sel && !parallel_host_port_req.wr;
        for (int e = 0; e < 2; e++) begin
            if (cpu_req.addr == EN_OFF[e]) begin
                cpu_rsp_next.data = enable_q[e];
            end
            if (cpu_req.addr == STAT_OFF[e]) begin
                cpu_rsp_next.data = status_view[e];
            end
            if (parallel_host_port_req.addr == EN_OFF[e]) begin
                hpp_rsp_next.data = enable_q[e];
            end
            if (parallel_host_port_req.addr == STAT_OFF[e]) begin
                hpp_rsp_next.data = status_view[e]; // [R14]
            end
        end
        if (!cpu_rsp_next.valid) begin
            cpu_rsp_next.data = 16'h0000;
        end
        if (!hpp_rsp_next.valid) begin
            hpp_rsp_next.data = 16'h0000;
        end
    end

    // Register the read answers so that they stand for exactly one cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            cpu_rsp_reg <= '0;
            parallel_host_port_rsp_reg <= '0;
        end else begin
            cpu_rsp_reg <= cpu_rsp_next;
            parallel_host_port_rsp_reg <= hpp_rsp_next;
        end
    end

endmodule : usb_host_interrupt_status
`default_nettype wire

/* core/usb_irq_cfg.svh */
`ifndef USB_IRQ_CFG_SVH
`define USB_IRQ_CFG_SVH

// ****************************************
// Register offsets of both host engines.
// ****************************************
`define HOST_ONE_ADDR_OFF 16'hC088
`define HOST_ONE_EN_OFF 16'hC08C
`define HOST_ONE_STAT_OFF 16'hC090
`define HOST_TWO_ADDR_OFF 16'hC0A8
`define HOST_TWO_EN_OFF 16'hC0AC
`define HOST_TWO_STAT_OFF 16'hC0B0

// ****************************************
// Bit positions in enable and status.
// ****************************************
`define BIT_VBUS 15
`define BIT_ID 14
`define BIT_SOF 9
`define BIT_WAKE_B 7
`define BIT_WAKE_A 6
`define BIT_CONN_B 5
`define BIT_CONN_A 4
`define BIT_SE0_B 3
`define BIT_SE0_A 2
`define BIT_DONE 0

// ****************************************
// Implemented bits and reset values.
// ****************************************
`define MASK_ENGINE_ONE 16'hC2F1
`define MASK_ENGINE_TWO 16'h02F1
`define MASK_SE0 16'h000C
`define ENABLE_RESET 16'h0000
`define FLAG_RESET 16'h0000
`define DEV_ADDR_RESET 7'h00

`endif

/* core/usb_irq_pkg.sv */
`default_nettype none
package usb_irq_pkg;

    // Events of one host engine, all sampled on clk.
    typedef struct packed {
        logic sof_expire;
        logic [1:0] wake;
        logic [1:0] se0;
        logic [1:0] host_ack;
        logic [1:0] dev_ack;
        logic [1:0] dev_nak;
        logic [1:0] dev_stall;
        logic [1:0] timeout;
    } host_event_t;

    // Register access request from one processor port.
    typedef struct packed {
        logic sel;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    // Registered read answer to one processor port.
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } reg_rsp_t;

endpackage : usb_irq_pkg
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "usb_irq_cfg.svh"
// ********************************
// Bench with a register model.
// ********************************
module testbench;
    import usb_irq_pkg::*;
    logic clk, rst, vbus, otg_id;
    reg_req_t cpu_req, pp_req;
    reg_rsp_t cpu_rsp, pp_rsp;
    host_event_t [1:0] ev;
    logic [1:0][6:0] dev_addr;
    logic [1:0] irq;
    logic [15:0] q;
    int err_total, check_count, seed, e, b, n;
    int en[2], fl[2], ad[2], sm[2];
    usb_host_interrupt_status u_usb_host_interrupt_status (.clk(clk), .rst(rst), .cpu_req(cpu_req),
        .cpu_rsp_reg(cpu_rsp), .parallel_host_port_req(pp_req), .parallel_host_port_rsp_reg(pp_rsp),
        .host_event(ev), .vbus_above_thresh(vbus), .otg_id(otg_id), .dev_addr_reg(dev_addr), .host_irq_reg(irq));
    usb_peer_model u_usb_peer_model (.clk(clk), .ev(ev), .vbus(vbus), .otg_id(otg_id));
    // Free-running clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    function automatic logic [15:0] msk(input int e);
        return e ? `MASK_ENGINE_TWO : `MASK_ENGINE_ONE;
    endfunction : msk
    // One access on port p, held for one edge; checks answer, irq and addresses.
    task automatic acc(input int p, input logic w, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        cpu_req <= '{p == 0, w, a, d};
        pp_req <= '{p != 0, w, a, d};
        @(posedge clk);
        cpu_req <= '0;
        pp_req <= '0;
        #1;
        q = p ? pp_rsp.data : cpu_rsp.data;
        chk({15'h0000, p ? pp_rsp.valid : cpu_rsp.valid}, {15'h0000, !w});
        chk({14'h0000, irq}, {14'h0000, (fl[1] & en[1]) != 0, (fl[0] & en[0]) != 0});
        chk({2'b00, dev_addr}, {2'b00, 7'(ad[1]), 7'(ad[0])});
    endtask : acc
    // Register k of engine e: 0 address, 1 enable, 2 status.
    task automatic wr(input int e, input int k, input int p, input logic [15:0] d);
        case (k)
            0: ad[e] = d[6:0];
            1: en[e] = d & msk(e);
            default: fl[e] &= ~d;
        endcase
        acc(p, 1'b1, 16'((e ? `HOST_TWO_ADDR_OFF : `HOST_ONE_ADDR_OFF) + 4 * k), d);
    endtask : wr
    task automatic rd(input int e, input int k, input int p);
        acc(p, 1'b0, 16'((e ? `HOST_TWO_ADDR_OFF : `HOST_ONE_ADDR_OFF) + 4 * k), 16'h0000);
        chk(q, 16'(k == 1 ? en[e] : k == 2 ? fl[e] | sm[e] << 2 : 0));
    endtask : rd
    task automatic fire(input int e, input int b);
        u_usb_peer_model.pulse(e, b);
        fl[e] |= 1 << (b == 14 ? 9 : b > 9 ? b - 6 : 0);
        rd(e, 2, b % 2);
    endtask : fire
    task automatic line(input int e, input int p, input int v);
        u_usb_peer_model.level(e, 10 + p, 1'(v));
        fl[e] |= (sm[e][p] != v) << (4 + p);
        sm[e][p] = v;
        rd(e, 2, 0);
    endtask : line
    task automatic otg(input logic vb, input logic id);
        fl[0] |= (vb != vbus) << 15 | (id != otg_id) << 14;
        u_usb_peer_model.otg(vb, id);
        rd(0, 2, 0);
        rd(1, 2, 1);
    endtask : otg
    // Main sequence.
    initial begin
        seed = 73719;
        cpu_req = '0;
        pp_req = '0;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (n = 0; n < 6; n++) begin
            rd(n / 3, n % 3, 0);
        end
        acc(0, 1'b0, 16'hC0FE, 16'h0000);
        chk(q, 16'h0000);
        for (n = 0; n < 4; n++) begin
            for (e = 0; e < 2; e++) begin
                wr(e, 1, n % 2, 16'($random(seed)) & msk(e));
                rd(e, 1, 1 - n % 2);
                for (b = 0; b < 15; b++) begin
                    if (b < 10 || b > 11) begin
                        fire(e, b);
                    end
                end
                wr(e, 2, 0, 16'h0000);
                wr(e, 2, 1, 16'($random(seed)) & msk(e));
                rd(e, 2, 0);
                wr(e, 0, n % 2, 16'($random(seed)) & 16'h007F);
            end
        end
        for (e = 0; e < 2; e++) begin
            for (b = 0; b < 2; b++) begin
                line(e, b, 1);
                line(e, b, 0);
            end
            wr(e, 2, 0, msk(e));
        end
        otg(1'b1, 1'b0);
        otg(1'b1, 1'b1);
        otg(1'b0, 1'b0);
        wr(0, 2, 1, msk(0));
        complete_run();
    end
    // Watchdog well beyond the expected run.
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        complete_run();
    end
endmodule : testbench
`default_nettype wire

/* dv/usb_irq_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// ********************************
// Port checks of the host block.
// ********************************
module usb_irq_assertions
    import usb_irq_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register ports.
    input wire reg_req_t cpu_req,
    input wire reg_rsp_t cpu_rsp_reg,
    input wire reg_req_t parallel_host_port_req,
    input wire reg_rsp_t parallel_host_port_rsp_reg,
    // Events and outputs.
    input wire host_event_t [1:0] host_event,
    input wire logic vbus_above_thresh,
    input wire logic otg_id,
    input wire logic [1:0][6:0] dev_addr_reg,
    input wire logic [1:0] host_irq_reg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic pulse0;
    logic addr_wr;
    // Pulses of engine one, and writes to its address from either side.
    assign pulse0 = |(host_event[0] & 15'h73FF);
    assign addr_wr = (cpu_req.sel && cpu_req.wr && cpu_req.addr == 16'hC088) ||
        (parallel_host_port_req.sel && parallel_host_port_req.wr && parallel_host_port_req.addr == 16'hC088);
    sequence rd_at(logic [15:0] a);
        cpu_req.sel && !cpu_req.wr && cpu_req.addr == a;
    endsequence
    sequence wr_at(logic [15:0] a);
        cpu_req.sel && cpu_req.wr && cpu_req.addr == a;
    endsequence
    chk_cpu_read_answer: assert property (cpu_req.sel && !cpu_req.wr |=> cpu_rsp_reg.valid)
        else $error("cpu read not answered");
    chk_port_read_answer: assert property (parallel_host_port_req.sel && !parallel_host_port_req.wr
        |=> parallel_host_port_rsp_reg.valid)
        else $error("host port read not answered");
    chk_se0_live: assert property (rd_at(16'hC090) |=> cpu_rsp_reg.data[3:2] == $past(host_event[0].se0))
        else $error("se0 status not live");
    chk_engine_two_otg: assert property (rd_at(16'hC0B0) |=> cpu_rsp_reg.data[15:14] == 2'b00)
        else $error("engine two otg bits set");
    chk_enable_reserved: assert property (rd_at(16'hC08C) |=> (cpu_rsp_reg.data & ~16'hC2F1) == 16'h0000)
        else $error("reserved enable bit set");
    chk_addr_load: assert property (wr_at(16'hC088) |=> dev_addr_reg[0] == $past(cpu_req.wdata[6:0]))
        else $error("address not loaded");
    chk_addr_hold: assert property (!addr_wr |=> $stable(dev_addr_reg[0]))
        else $error("address changed unasked");
    // Full clear of engine one with no new event of any kind in that cycle.
    sequence quiet_clear;
        (cpu_req.wdata & 16'hC2F1) == 16'hC2F1 && !pulse0 && $stable(host_event[0].se0)
            && $stable(vbus_above_thresh) && $stable(otg_id);
    endsequence
    chk_clear_drops_irq: assert property (wr_at(16'hC090) ##0 quiet_clear |=> !host_irq_reg[0])
        else $error("irq kept after full clear");
endmodule : usb_irq_assertions
bind usb_host_interrupt_status usb_irq_assertions u_chk (.clk(clk), .rst(rst), .cpu_req(cpu_req),
    .cpu_rsp_reg(cpu_rsp_reg), .parallel_host_port_req(parallel_host_port_req),
    .parallel_host_port_rsp_reg(parallel_host_port_rsp_reg), .host_event(host_event),
    .vbus_above_thresh(vbus_above_thresh), .otg_id(otg_id), .dev_addr_reg(dev_addr_reg), .host_irq_reg(host_irq_reg));
`default_nettype wire

/* dv/usb_peer_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ********************************
// Peripherals on both engines.
// ********************************
module usb_peer_model
    import usb_irq_pkg::*;
(
    // Clock.
    input wire logic clk,
    // Line events and OTG levels.
    output var host_event_t [1:0] ev,
    output var logic vbus,
    output var logic otg_id
);
    // Lines start quiet.
    initial begin
        ev = '0;
        vbus = 1'b0;
        otg_id = 1'b0;
    end
    // One-cycle pulse of bit b of the event word.
    task automatic pulse(input int e, input int b);
        @(posedge clk);
        ev[e][b] <= 1'b1;
        @(posedge clk);
        ev[e][b] <= 1'b0;
    endtask : pulse
    // SE0 level of a port; one means detached.
    task automatic level(input int e, input int b, input logic v);
        @(posedge clk);
        ev[e][b] <= v;
        @(posedge clk);
    endtask : level
    // Bus voltage and ID levels of the OTG port.
    task automatic otg(input logic vb, input logic id);
        @(posedge clk);
        vbus <= vb;
        otg_id <= id;
        @(posedge clk);
    endtask : otg
endmodule : usb_peer_model
`default_nettype wire
